/* design/lhdsr_regs.sv */
// Limp-home current and dimming width set-point register bank
`timescale 1ns/1ps
`include "lhdsr_cfg.svh"
module lhdsr_regs (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   output logic [7:0] RDATA_O,
   output logic HIT_O,
   input wire logic LIMP_HOME_I,
   output logic [9:0] CH1_BACKUP_CURRENT_SETPOINT_O,
   output logic [9:0] CH2_BACKUP_CURRENT_SETPOINT_O,
   output logic [9:0] CH1_BACKUP_DIM_WIDTH_O,
   output logic [9:0] CH2_BACKUP_DIM_WIDTH_O
);
   localparam int NREG = 8;
   lhdsr_pkg::lhdsr_req_t req;
   logic [7:0] regs_r [NREG];
   logic [7:0] regs_nxt [NREG];
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [NREG-1:0] sel;
   lhdsr_pkg::lhdsr_chan_t ch1_stored;
   lhdsr_pkg::lhdsr_chan_t ch2_stored;
   lhdsr_pkg::lhdsr_chan_t stored [2];
   lhdsr_pkg::lhdsr_chan_t applied [2];

   assign req = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};

   // Offset map; index order follows the address order
   localparam logic [7:0] OFS [NREG] = '{
      `LHDSR_OFS_CH1_CUR_LOW, `LHDSR_OFS_CH1_CUR_HIGH,
      `LHDSR_OFS_CH2_CUR_LOW, `LHDSR_OFS_CH2_CUR_HIGH,
      `LHDSR_OFS_CH1_WID_LOW, `LHDSR_OFS_CH1_WID_HIGH,
      `LHDSR_OFS_CH2_WID_LOW, `LHDSR_OFS_CH2_WID_HIGH};
   // Registers that hold only two bits
   localparam logic [NREG-1:0] NARROW = `LHDSR_NARROW_MASK;

   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_reg
         assign sel[g] = (req.addr == OFS[g]);
         always_comb begin
            regs_nxt[g] = regs_r[g];
            if (req.wr && sel[g]) begin
               regs_nxt[g] = NARROW[g] ? (req.wdata & `LHDSR_PAIR_MASK)
                                       : req.wdata;
            end
         end
         always_ff @(posedge CLK_I or posedge RST_I) begin
            if (RST_I) begin
               regs_r[g] <= `LHDSR_REG_RESET;
            end else begin
               regs_r[g] <= regs_nxt[g];
            end
         end
      end
   endgenerate

   always_comb begin
      rdata_nxt = rdata_r;
      if (req.rd) begin
         rdata_nxt = 8'h00;
         for (int i = 0; i < NREG; i++) begin
            if (sel[i]) begin
               rdata_nxt = regs_r[i];
            end
         end
      end
   end
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign RDATA_O = rdata_r;
   assign HIT_O = |sel;

   // Current: high byte on top; width: low byte at the bottom
   assign ch1_stored.current = {regs_r[1], regs_r[0][1:0]};
   assign ch2_stored.current = {regs_r[3], regs_r[2][1:0]};
   assign ch1_stored.width = {regs_r[5][1:0], regs_r[4]};
   assign ch2_stored.width = {regs_r[7][1:0], regs_r[6]};

   // Hold stage keeps the generators steady outside limp-home mode while software edits halves
   assign stored[0] = ch1_stored;
   assign stored[1] = ch2_stored;
   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_chan
         lhdsr_hold u_hold (
            .clk_i(CLK_I),
            .rst_i(RST_I),
            .limp_i(LIMP_HOME_I),
            .stored_i(stored[c]),
            .applied_o(applied[c])
         );
      end
   endgenerate
   assign CH1_BACKUP_CURRENT_SETPOINT_O = applied[0].current;
   assign CH2_BACKUP_CURRENT_SETPOINT_O = applied[1].current;
   assign CH1_BACKUP_DIM_WIDTH_O = applied[0].width;
   assign CH2_BACKUP_DIM_WIDTH_O = applied[1].width;

   // Byte written, one edge in limp-home mode, then seen on the pins
   a_ch1_cur_low: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      WR_I && ADDR_I == `LHDSR_OFS_CH1_CUR_LOW ##1 LIMP_HOME_I ##1 1'b1
      |-> CH1_BACKUP_CURRENT_SETPOINT_O[1:0] == $past(WDATA_I[1:0], 2))
      else $error("Channel 1 current low bits misplaced");

   a_ch1_cur_high: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      WR_I && ADDR_I == `LHDSR_OFS_CH1_CUR_HIGH ##1 LIMP_HOME_I ##1 1'b1
      |-> CH1_BACKUP_CURRENT_SETPOINT_O[9:2] == $past(WDATA_I, 2))
      else $error("Channel 1 current high byte misplaced");

   a_ch2_cur_low: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      WR_I && ADDR_I == `LHDSR_OFS_CH2_CUR_LOW ##1 LIMP_HOME_I ##1 1'b1
      |-> CH2_BACKUP_CURRENT_SETPOINT_O[1:0] == $past(WDATA_I[1:0], 2))
      else $error("Channel 2 current low bits misplaced");

   a_ch2_cur_high: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      WR_I && ADDR_I == `LHDSR_OFS_CH2_CUR_HIGH ##1 LIMP_HOME_I ##1 1'b1
      |-> CH2_BACKUP_CURRENT_SETPOINT_O[9:2] == $past(WDATA_I, 2))
      else $error("Channel 2 current high byte misplaced");

   a_ch1_wid_low: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      WR_I && ADDR_I == `LHDSR_OFS_CH1_WID_LOW ##1 LIMP_HOME_I ##1 1'b1
      |-> CH1_BACKUP_DIM_WIDTH_O[7:0] == $past(WDATA_I, 2))
      else $error("Channel 1 width low byte misplaced");

   a_ch1_wid_high: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      WR_I && ADDR_I == `LHDSR_OFS_CH1_WID_HIGH ##1 LIMP_HOME_I ##1 1'b1
      |-> CH1_BACKUP_DIM_WIDTH_O[9:8] == $past(WDATA_I[1:0], 2))
      else $error("Channel 1 width high bits misplaced");

   a_ch2_wid_low: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      WR_I && ADDR_I == `LHDSR_OFS_CH2_WID_LOW ##1 LIMP_HOME_I ##1 1'b1
      |-> CH2_BACKUP_DIM_WIDTH_O[7:0] == $past(WDATA_I, 2))
      else $error("Channel 2 width low byte misplaced");

   a_ch2_wid_high: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      WR_I && ADDR_I == `LHDSR_OFS_CH2_WID_HIGH ##1 LIMP_HOME_I ##1 1'b1
      |-> CH2_BACKUP_DIM_WIDTH_O[9:8] == $past(WDATA_I[1:0], 2))
      else $error("Channel 2 width high bits misplaced");

   a_reset_clears_all: assert property (@(posedge CLK_I)
      $fell(RST_I)
      |-> RDATA_O == `LHDSR_REG_RESET
      && CH1_BACKUP_CURRENT_SETPOINT_O == `LHDSR_VAL_RESET
      && CH2_BACKUP_CURRENT_SETPOINT_O == `LHDSR_VAL_RESET
      && CH1_BACKUP_DIM_WIDTH_O == `LHDSR_VAL_RESET
      && CH2_BACKUP_DIM_WIDTH_O == `LHDSR_VAL_RESET)
      else $error("Outputs not cleared by reset");

   // Read path
   a_reserved_read_zero: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      RD_I && (ADDR_I == `LHDSR_OFS_CH1_CUR_LOW
      || ADDR_I == `LHDSR_OFS_CH2_CUR_LOW
      || ADDR_I == `LHDSR_OFS_CH1_WID_HIGH
      || ADDR_I == `LHDSR_OFS_CH2_WID_HIGH)
      |=> RDATA_O[7:2] == 6'h00)
      else $error("Reserved bits read nonzero");

   a_unmapped_read_zero: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      RD_I && !HIT_O |=> RDATA_O == 8'h00)
      else $error("Unmapped read returned nonzero");

   a_rdata_stands: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      !RD_I |=> $stable(RDATA_O))
      else $error("Read data moved without a read");

   a_hit_decode: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      HIT_O == (ADDR_I >= `LHDSR_OFS_CH1_CUR_LOW
      && ADDR_I <= `LHDSR_OFS_CH2_WID_HIGH))
      else $error("Address hit flag wrong");

   // Unmapped or absent writes must leave every set point alone
   a_stored_write_only: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      !(WR_I && HIT_O) |=> $stable(ch1_stored) && $stable(ch2_stored))
      else $error("Stored set point moved without a mapped write");

   // Pins freeze outside the mode and follow one edge behind inside it
   a_outputs_frozen: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      !$past(LIMP_HOME_I)
      |-> $stable(CH1_BACKUP_CURRENT_SETPOINT_O)
      && $stable(CH2_BACKUP_CURRENT_SETPOINT_O)
      && $stable(CH1_BACKUP_DIM_WIDTH_O)
      && $stable(CH2_BACKUP_DIM_WIDTH_O))
      else $error("Channel outputs moved outside limp-home mode");

   a_outputs_follow: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      LIMP_HOME_I
      |=> CH1_BACKUP_CURRENT_SETPOINT_O == $past(ch1_stored.current)
      && CH2_BACKUP_CURRENT_SETPOINT_O == $past(ch2_stored.current)
      && CH1_BACKUP_DIM_WIDTH_O == $past(ch1_stored.width)
      && CH2_BACKUP_DIM_WIDTH_O == $past(ch2_stored.width))
      else $error("Channel outputs did not follow stored values");
endmodule : lhdsr_regs

/* design/lhdsr_cfg.svh */
// Offsets, field positions and reset values of the limp-home set-point bank
`ifndef LHDSR_CFG_SVH
`define LHDSR_CFG_SVH
`define LHDSR_OFS_CH1_CUR_LOW 8'h24
`define LHDSR_OFS_CH1_CUR_HIGH 8'h25
`define LHDSR_OFS_CH2_CUR_LOW 8'h26
`define LHDSR_OFS_CH2_CUR_HIGH 8'h27
`define LHDSR_OFS_CH1_WID_LOW 8'h28
`define LHDSR_OFS_CH1_WID_HIGH 8'h29
`define LHDSR_OFS_CH2_WID_LOW 8'h2A
`define LHDSR_OFS_CH2_WID_HIGH 8'h2B
`define LHDSR_REG_RESET 8'h00
`define LHDSR_VAL_RESET 10'h000
`define LHDSR_PAIR_BITS 2
`define LHDSR_PAIR_MASK 8'h03
`define LHDSR_NARROW_MASK 8'hA5
`endif

/* design/lhdsr_pkg.sv */
// Types of the limp-home set-point bank
package lhdsr_pkg;
   typedef struct packed {
      logic [9:0] current;
      logic [9:0] width;
   } lhdsr_chan_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lhdsr_req_t;
endpackage : lhdsr_pkg

/* design/lhdsr_hold.sv */
// Output stage: passes set points on in limp-home mode, else holds
`timescale 1ns/1ps
module lhdsr_hold (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic limp_i,
   input wire lhdsr_pkg::lhdsr_chan_t stored_i,
   output lhdsr_pkg::lhdsr_chan_t applied_o
);
   lhdsr_pkg::lhdsr_chan_t app_r;
   lhdsr_pkg::lhdsr_chan_t app_nxt;
   always_comb begin
      app_nxt = app_r;
      if (limp_i) begin
         app_nxt = stored_i;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         app_r <= '0;
      end else begin
         app_r <= app_nxt;
      end
   end
   assign applied_o = app_r;
   a_hold_outside_limp: assert property (@(posedge clk_i)
      disable iff (rst_i)
      !$past(limp_i) |-> $stable(applied_o))
      else $error("Applied value moved outside limp-home mode");
   a_follow_in_limp: assert property (@(posedge clk_i)
      disable iff (rst_i)
      limp_i ##1 1'b1 |-> applied_o == $past(stored_i))
      else $error("Applied value did not follow stored value");
endmodule : lhdsr_hold

/* testbench/lhdsr_host.sv */
// Host model driving the register port of the set-point bank
`timescale 1ns/1ps
module lhdsr_host (
   input wire logic clk_i,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // Called just after an edge; idle cycle after each keeps strobes clean
   task automatic access(input logic w, input logic [7:0] a,
                         input logic [7:0] d);
      wr_o <= w;
      rd_o <= !w;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
      @(posedge clk_i);
   endtask : access
endmodule : lhdsr_host

/* testbench/lhdsr_regs_bench.sv */
// Self-checking bench for the limp-home set-point bank
`timescale 1ns/1ps
`include "lhdsr_cfg.svh"
module lhdsr_regs_bench;
   localparam logic [7:0] BASE = `LHDSR_OFS_CH1_CUR_LOW;
   logic clk, rst, limp, wr, rd, hit;
   logic [7:0] addr, wdata, rdata;
   logic [7:0] exp_rd;
   logic [9:0] c1, c2, w1, w2;
   logic [7:0] d [8] = '{8'h5B, 8'hC6, 8'hE9, 8'h71, 8'h3A, 8'h9D, 8'h4E,
      8'hB2};
   int num_errors = 0;
   int total_checks = 0;
   lhdsr_host host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
      .wdata_o(wdata));
   lhdsr_regs dut (.CLK_I(clk), .RST_I(rst), .WR_I(wr), .RD_I(rd),
      .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .HIT_O(hit),
      .LIMP_HOME_I(limp), .CH1_BACKUP_CURRENT_SETPOINT_O(c1),
      .CH2_BACKUP_CURRENT_SETPOINT_O(c2), .CH1_BACKUP_DIM_WIDTH_O(w1),
      .CH2_BACKUP_DIM_WIDTH_O(w2));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input string n, input logic [9:0] e,
                        input logic [9:0] s);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic mapped;
      mapped = a >= `LHDSR_OFS_CH1_CUR_LOW && a <= `LHDSR_OFS_CH2_WID_HIGH;
      fork
         host.access(1'b0, a, 8'h00);
         begin
            @(negedge clk);
            check("hit", {9'h000, mapped}, {9'h000, hit});
         end
      join
      check("rdata", {2'b00, e}, {2'b00, rdata});
   endtask : rd_chk
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      rst = 1'b1;
      limp = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 8; i++) rd_chk(8'(BASE + i), 8'h00);
      $display("reset test done");
      for (int i = 0; i < 8; i++) host.access(1'b1, 8'(BASE + i), d[i]);
      // Two-bit registers keep only their low pair
      for (int i = 0; i < 8; i++) begin
         exp_rd = i inside {0, 2, 5, 7} ? d[i] & 8'h03 : d[i];
         rd_chk(8'(BASE + i), exp_rd);
      end
      // Unmapped write is dropped and read data stands until a read
      host.access(1'b1, 8'h2C, 8'hFF);
      check("rdata held", {2'b00, exp_rd}, {2'b00, rdata});
      rd_chk(8'h2C, 8'h00);
      check("ch1 cur idle", 10'h000, c1);
      $display("readback test done");
      limp <= 1'b1;
      repeat (2) @(posedge clk);
      check("ch1 cur", {d[1], d[0][1:0]}, c1);
      check("ch2 cur", {d[3], d[2][1:0]}, c2);
      check("ch1 wid", {d[5][1:0], d[4]}, w1);
      check("ch2 wid", {d[7][1:0], d[6]}, w2);
      limp <= 1'b0;
      @(posedge clk);
      host.access(1'b1, `LHDSR_OFS_CH1_CUR_HIGH, 8'h00);
      repeat (2) @(posedge clk);
      check("ch1 cur held", {d[1], d[0][1:0]}, c1);
      $display("limp test done");
      // Writes while the mode is on reach the pins one edge later
      limp <= 1'b1;
      for (int i = 0; i < 8; i++) host.access(1'b1, 8'(BASE + i), ~d[i]);
      @(posedge clk);
      check("ch1 cur live", {~d[1], ~d[0][1:0]}, c1);
      check("ch2 cur live", {~d[3], ~d[2][1:0]}, c2);
      check("ch1 wid live", {~d[5][1:0], ~d[4]}, w1);
      check("ch2 wid live", {~d[7][1:0], ~d[6]}, w2);
      $display("live write test done");
      rst <= 1'b1;
      limp <= 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("ch1 cur rst", 10'h000, c1);
      check("ch2 cur rst", 10'h000, c2);
      check("ch1 wid rst", 10'h000, w1);
      check("ch2 wid rst", 10'h000, w2);
      for (int i = 0; i < 8; i++) rd_chk(8'(BASE + i), 8'h00);
      $display("mid-run reset test done");
      report_and_stop();
   end
endmodule : lhdsr_regs_bench
